// file: hw/irt_defines.svh
// Purpose: Constants for the interrupt response timing block
// Assumes: All counts are in CPU system clock states
// Notes: Memory access states are added by the bus acknowledge
`ifndef IRT_DEFINES_SVH
`define IRT_DEFINES_SVH
`define IRT_NUM_PINS 8
`define IRT_RES_INT 2
`define IRT_RES_EXT 3
`define IRT_ENTRY_FIXED 5
`define IRT_ENTRY_LEAD 1
`define IRT_ENTRY_GAP (`IRT_ENTRY_FIXED - `IRT_ENTRY_LEAD)
`define IRT_CNT_W 16
`define IRT_PIN_IDLE 8'hff
`define IRT_SENSE_RST 8'h00
`endif

// file: hw/irt_pkg.sv
// Purpose: Types for the interrupt response timing block
// Assumes: Constants come from irt_defines.svh
// Notes: One-hot state codes written out
package irt_pkg;
   typedef enum logic [8:0] {
      ST_IDLE = 9'h001,
      ST_RESOLVE = 9'h002,
      ST_WAIT = 9'h004,
      ST_ENTRY = 9'h008,
      ST_SR_SAVE = 9'h010,
      ST_PC_SAVE = 9'h020,
      ST_VEC_READ = 9'h040,
      ST_GAP = 9'h080,
      ST_FETCH = 9'h100
   } state_t;
   typedef enum logic [1:0] {
      OP_SR_WRITE = 2'h0,
      OP_PC_WRITE = 2'h1,
      OP_VEC_READ = 2'h2,
      OP_FETCH = 2'h3
   } mem_op_t;
endpackage

// file: hw/sense_if.sv
// Purpose: Carries pin requests and their clears between modules
// Assumes: One clock domain
// Notes: Clear is a one-cycle pulse per pin
`timescale 1ns/1ps
`include "irt_defines.svh"
interface sense_if;
   logic [`IRT_NUM_PINS-1:0] req;
   logic [`IRT_NUM_PINS-1:0] clr;
   modport src (output req, input clr);
   modport sink (input req, output clr);
endinterface

// file: hw/irq_sense.sv
// Purpose: Low level or falling edge detection for the interrupt pins
// Assumes: Pins synchronous to the clock, active low
// Notes: A pin in general input use looks high to the detector
`timescale 1ns/1ps
`include "irt_defines.svh"
module irq_sense (
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic [`IRT_NUM_PINS-1:0] i_pin_n,
   input wire logic [`IRT_NUM_PINS-1:0] i_pin_is_irq,
   input wire logic [`IRT_NUM_PINS-1:0] i_sense_edge,
   sense_if.src sb
);
   logic [`IRT_NUM_PINS-1:0] seen;
   logic [`IRT_NUM_PINS-1:0] prev_ff;
   logic [`IRT_NUM_PINS-1:0] pend_ff;
   logic [`IRT_NUM_PINS-1:0] lvl_ff;
   logic [`IRT_NUM_PINS-1:0] fall;

   // Switching to interrupt use while low makes a falling edge
   assign seen = i_pin_n | ~i_pin_is_irq;
   assign fall = prev_ff & ~seen;

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         prev_ff <= `IRT_PIN_IDLE;
      end else begin
         prev_ff <= seen;
      end
   end

   // Edge held once; a new edge beats a clear
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         pend_ff <= `IRT_SENSE_RST;
      end else begin
         pend_ff <= (pend_ff & ~sb.clr) | fall;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         lvl_ff <= `IRT_SENSE_RST;
      end else begin
         lvl_ff <= ~seen;
      end
   end

   assign sb.req = (i_sense_edge & pend_ff) | (~i_sense_edge & lvl_ff);

   a_edge_switch_low: assert property (@(posedge i_clk_sys)
      disable iff (!i_rstn)
      (i_sense_edge[0] && !i_pin_n[0] && !$past(i_pin_is_irq[0])
       && i_pin_is_irq[0] && !sb.clr[0]) |=> sb.req[0])
      else $error("Switch while low gave no edge request");
   a_level_follow: assert property (@(posedge i_clk_sys)
      disable iff (!i_rstn)
      (!i_pin_n[0] && i_pin_is_irq[0]) ##1 !i_sense_edge[0]
      |-> sb.req[0])
      else $error("Low level request missing");
   c_edge_switch: cover property (@(posedge i_clk_sys)
      disable iff (!i_rstn) $rose(i_pin_is_irq[0]) && !i_pin_n[0]);
endmodule // irq_sense

// file: hw/interrupt_response_timing.sv
// Purpose: Interrupt acceptance and exception entry timing
// Assumes: Memory acknowledge marks the last state of each access
// Notes: Response counted from the first resolution state
`timescale 1ns/1ps
`include "irt_defines.svh"
// Notes on behaviour
// - Response time runs from the request until the handler fetch starts.
// - Acceptance waits while the CPU finishes its current sequence.
// - A following masking instruction can stretch that wait without bound.
// - Entry to handler fetch takes 5 states plus the three access lengths.
// - Entry does status write, counter write, vector read, then fetch.
// - Resolution takes 2 states internal and 3 for pins, min 10 and 11.
// - Response is 7 or 8 plus the access lengths and the wait states.
// - Switching a pin to interrupt use while low in edge mode requests.
// - Each pin sense bit picks low level at 0 or falling edge at 1.
module interrupt_response_timing (
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic i_nmi_req,
   input wire logic i_onchip_req,
   input wire logic [3:0] i_onchip_level,
   input wire logic [3:0] i_irq_level,
   input wire logic [3:0] i_sr_mask,
   input wire logic [`IRT_NUM_PINS-1:0] i_irq_pin_n,
   input wire logic [`IRT_NUM_PINS-1:0] i_pin_is_irq,
   input wire logic [`IRT_NUM_PINS-1:0] i_sense_edge,
   input wire logic i_cpu_busy,
   input wire logic i_mask_hold,
   input wire logic i_mem_ack,
   output logic o_irq_out_n,
   output logic o_exc_start,
   output logic o_mem_req,
   output irt_pkg::mem_op_t o_mem_op,
   output logic o_fetch_start,
   output logic [`IRT_CNT_W-1:0] o_resp_cycles
);
   sense_if sb ();
   irt_pkg::state_t state_ff;
   irt_pkg::state_t nxt_state;
   logic [`IRT_CNT_W-1:0] cnt_ff;
   logic [`IRT_CNT_W-1:0] wait_cnt_ff;
   logic [`IRT_CNT_W-1:0] msum_ff;
   logic ext_ff;
   logic [`IRT_NUM_PINS-1:0] pin_sel_ff;
   logic [`IRT_NUM_PINS-1:0] pin_pick;
   logic onchip_ok;
   logic pin_ok;
   logic any_req;
   logic res_last;
   logic gap_last;

   function automatic logic above(input logic [3:0] lvl,
                                  input logic [3:0] msk);
      above = lvl > msk;
   endfunction

   irq_sense u_sense (
      .i_clk_sys(i_clk_sys),
      .i_rstn(i_rstn),
      .i_pin_n(i_irq_pin_n),
      .i_pin_is_irq(i_pin_is_irq),
      .i_sense_edge(i_sense_edge),
      .sb(sb.src)
   );

   // Lowest numbered pin wins among pins
   assign pin_pick = sb.req & (~sb.req + 8'h01);
   assign onchip_ok = i_onchip_req && above(i_onchip_level, i_sr_mask);
   assign pin_ok = (|sb.req) && above(i_irq_level, i_sr_mask);
   assign any_req = i_nmi_req || onchip_ok || pin_ok;
   assign res_last = ext_ff ? (cnt_ff == `IRT_CNT_W'(`IRT_RES_EXT - 1))
                            : (cnt_ff == `IRT_CNT_W'(`IRT_RES_INT - 1));
   assign gap_last = (cnt_ff == msum_ff + wait_cnt_ff
                     + `IRT_CNT_W'(`IRT_ENTRY_FIXED - 1)
                     + (ext_ff ? `IRT_CNT_W'(`IRT_RES_EXT)
                               : `IRT_CNT_W'(`IRT_RES_INT)));

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         irt_pkg::ST_IDLE: begin
            if (any_req) begin
               nxt_state = irt_pkg::ST_RESOLVE;
            end
         end
         irt_pkg::ST_RESOLVE: begin
            if (res_last) begin
               // Wait for the CPU sequence, or a masking instruction
               nxt_state = (i_cpu_busy || i_mask_hold) ? irt_pkg::ST_WAIT
                                                       : irt_pkg::ST_ENTRY;
            end
         end
         irt_pkg::ST_WAIT: begin
            if (!i_cpu_busy && !i_mask_hold) begin
               nxt_state = irt_pkg::ST_ENTRY;
            end
         end
         irt_pkg::ST_ENTRY: nxt_state = irt_pkg::ST_SR_SAVE;
         irt_pkg::ST_SR_SAVE: begin
            if (i_mem_ack) begin
               nxt_state = irt_pkg::ST_PC_SAVE;
            end
         end
         irt_pkg::ST_PC_SAVE: begin
            if (i_mem_ack) begin
               nxt_state = irt_pkg::ST_VEC_READ;
            end
         end
         irt_pkg::ST_VEC_READ: begin
            if (i_mem_ack) begin
               nxt_state = irt_pkg::ST_GAP;
            end
         end
         irt_pkg::ST_GAP: begin
            if (gap_last) begin
               nxt_state = irt_pkg::ST_FETCH;
            end
         end
         irt_pkg::ST_FETCH: begin
            if (i_mem_ack) begin
               nxt_state = irt_pkg::ST_IDLE;
            end
         end
         default: nxt_state = irt_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         state_ff <= irt_pkg::ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Source class latched when a request is seen in idle
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         ext_ff <= 1'b0;
         pin_sel_ff <= `IRT_SENSE_RST;
      end else if (state_ff == irt_pkg::ST_IDLE && any_req) begin
         ext_ff <= !i_nmi_req && !onchip_ok;
         pin_sel_ff <= (!i_nmi_req && !onchip_ok) ? pin_pick
                                                  : `IRT_SENSE_RST;
      end
   end

   // Pending edge dropped when entry replaces the next instruction
   assign sb.clr = (state_ff == irt_pkg::ST_ENTRY) ? pin_sel_ff
                                                   : `IRT_SENSE_RST;

   // Elapsed states since the first resolution state
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         cnt_ff <= '0;
      end else if (state_ff == irt_pkg::ST_IDLE) begin
         cnt_ff <= '0;
      end else if (state_ff != irt_pkg::ST_FETCH) begin
         cnt_ff <= cnt_ff + `IRT_CNT_W'(1);
      end
   end

   // Access states and wait states, each access adds its own length
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         msum_ff <= '0;
         wait_cnt_ff <= '0;
      end else if (state_ff == irt_pkg::ST_IDLE) begin
         msum_ff <= '0;
         wait_cnt_ff <= '0;
      end else begin
         if (state_ff == irt_pkg::ST_SR_SAVE
             || state_ff == irt_pkg::ST_PC_SAVE
             || state_ff == irt_pkg::ST_VEC_READ) begin
            msum_ff <= msum_ff + `IRT_CNT_W'(1);
         end
         if (state_ff == irt_pkg::ST_WAIT) begin
            wait_cnt_ff <= wait_cnt_ff + `IRT_CNT_W'(1);
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         o_irq_out_n <= 1'b1;
         o_exc_start <= 1'b0;
         o_fetch_start <= 1'b0;
         o_resp_cycles <= '0;
      end else begin
         o_irq_out_n <= !(nxt_state == irt_pkg::ST_WAIT
                          || nxt_state == irt_pkg::ST_ENTRY);
         o_exc_start <= nxt_state == irt_pkg::ST_ENTRY
                        && state_ff != irt_pkg::ST_ENTRY;
         o_fetch_start <= nxt_state == irt_pkg::ST_FETCH
                          && state_ff != irt_pkg::ST_FETCH;
         if (state_ff == irt_pkg::ST_GAP && gap_last) begin
            o_resp_cycles <= cnt_ff + `IRT_CNT_W'(1);
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         o_mem_op <= irt_pkg::OP_SR_WRITE;
      end else begin
         case (nxt_state)
            irt_pkg::ST_PC_SAVE: o_mem_op <= irt_pkg::OP_PC_WRITE;
            irt_pkg::ST_VEC_READ: o_mem_op <= irt_pkg::OP_VEC_READ;
            irt_pkg::ST_FETCH: o_mem_op <= irt_pkg::OP_FETCH;
            default: o_mem_op <= irt_pkg::OP_SR_WRITE;
         endcase
      end
   end

   assign o_mem_req = state_ff == irt_pkg::ST_SR_SAVE
                      || state_ff == irt_pkg::ST_PC_SAVE
                      || state_ff == irt_pkg::ST_VEC_READ
                      || state_ff == irt_pkg::ST_FETCH;

   a_resolve_int: assert property (@(posedge i_clk_sys)
      disable iff (!i_rstn)
      $rose(state_ff == irt_pkg::ST_RESOLVE) && !ext_ff
      |-> (state_ff == irt_pkg::ST_RESOLVE)[*2]
          ##1 state_ff != irt_pkg::ST_RESOLVE)
      else $error("Internal resolution not two states");
   a_resolve_ext: assert property (@(posedge i_clk_sys)
      disable iff (!i_rstn)
      $rose(state_ff == irt_pkg::ST_RESOLVE) && ext_ff
      |-> (state_ff == irt_pkg::ST_RESOLVE)[*3]
          ##1 state_ff != irt_pkg::ST_RESOLVE)
      else $error("Pin resolution not three states");
   a_wait_busy: assert property (@(posedge i_clk_sys)
      disable iff (!i_rstn)
      state_ff == irt_pkg::ST_WAIT && (i_cpu_busy || i_mask_hold)
      |=> state_ff == irt_pkg::ST_WAIT)
      else $error("Left wait while CPU busy");
   a_sr_then_pc: assert property (@(posedge i_clk_sys)
      disable iff (!i_rstn)
      o_mem_req && o_mem_op == irt_pkg::OP_SR_WRITE && i_mem_ack
      |=> o_mem_req && o_mem_op == irt_pkg::OP_PC_WRITE)
      else $error("Counter save did not follow status save");
   a_pc_then_vec: assert property (@(posedge i_clk_sys)
      disable iff (!i_rstn)
      o_mem_req && o_mem_op == irt_pkg::OP_PC_WRITE && i_mem_ack
      |=> o_mem_req && o_mem_op == irt_pkg::OP_VEC_READ)
      else $error("Vector read did not follow counter save");
   a_gap_to_fetch: assert property (@(posedge i_clk_sys)
      disable iff (!i_rstn)
      o_mem_op == irt_pkg::OP_VEC_READ && o_mem_req && i_mem_ack
      |-> ##5 o_fetch_start && o_mem_op == irt_pkg::OP_FETCH)
      else $error("Fetch not five states after vector read");
   a_entry_length: assert property (@(posedge i_clk_sys)
      disable iff (!i_rstn)
      o_exc_start |-> ##[5:1000] o_fetch_start)
      else $error("Entry shorter than five states");
   a_resp_total: assert property (@(posedge i_clk_sys)
      disable iff (!i_rstn)
      o_fetch_start |-> o_resp_cycles == msum_ff + wait_cnt_ff
         + (ext_ff ? `IRT_CNT_W'(8) : `IRT_CNT_W'(7)))
      else $error("Response total wrong");
   a_min_resp: assert property (@(posedge i_clk_sys)
      disable iff (!i_rstn)
      o_fetch_start |-> o_resp_cycles >= (ext_ff ? `IRT_CNT_W'(11)
                                                 : `IRT_CNT_W'(10)))
      else $error("Response below minimum");
   c_int_fast: cover property (@(posedge i_clk_sys)
      disable iff (!i_rstn)
      o_fetch_start && !ext_ff && o_resp_cycles == `IRT_CNT_W'(10));
   c_ext_fast: cover property (@(posedge i_clk_sys)
      disable iff (!i_rstn)
      o_fetch_start && ext_ff && o_resp_cycles == `IRT_CNT_W'(11));
   c_waited: cover property (@(posedge i_clk_sys)
      disable iff (!i_rstn)
      o_fetch_start && wait_cnt_ff != '0);
endmodule // interrupt_response_timing

// file: sim/cpu_mem_model.sv
// Purpose: Memory side of the CPU core for exception entry accesses
// Assumes: Every access lasts i_lat states, ack in its last state
// Notes: Ack falls with the request, so no stale ack outside access
`timescale 1ns/1ps
module cpu_mem_model (
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic i_mem_req,
   input wire logic [2:0] i_lat,
   output logic o_mem_ack
);
   logic [2:0] cnt_ff;
   assign o_mem_ack = i_mem_req && (cnt_ff == i_lat);
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         cnt_ff <= 3'h1;
      end else if (!i_mem_req || o_mem_ack) begin
         cnt_ff <= 3'h1;
      end else begin
         cnt_ff <= cnt_ff + 3'h1;
      end
   end
endmodule // cpu_mem_model

// file: sim/interrupt_response_timing_test.sv
// Purpose: Self-checking bench for interrupt response timing
// Assumes: All accesses of one transfer share one latency
// Notes: Outputs read right after an edge show pre-edge values
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
   $display("BAD t=%0t mismatch %0d %0d", $time, (a), (b)); end end
module interrupt_response_timing_test;
   logic i_clk_sys = 0, i_rstn = 0, i_nmi_req = 0, i_onchip_req = 0;
   logic i_cpu_busy = 0, i_mask_hold = 0, i_mem_ack;
   logic [3:0] i_onchip_level = 0, i_irq_level = 4'hf, i_sr_mask = 0;
   logic [7:0] i_irq_pin_n = 8'hff, i_pin_is_irq = 8'hff;
   logic [7:0] i_sense_edge = 8'h00;
   logic o_irq_out_n, o_exc_start, o_mem_req, o_fetch_start;
   irt_pkg::mem_op_t o_mem_op;
   logic [15:0] o_resp_cycles, resp;
   logic [2:0] lat = 3'h1;
   int n_fail = 0, comparisons = 0, cyc = 0, got, ivl;
   int unsigned seed = 14696, r, m;
   irt_pkg::mem_op_t ops[$];
   interrupt_response_timing uut (.i_clk_sys, .i_rstn, .i_nmi_req,
      .i_onchip_req, .i_onchip_level, .i_irq_level, .i_sr_mask, .i_irq_pin_n,
      .i_pin_is_irq, .i_sense_edge, .i_cpu_busy, .i_mask_hold, .i_mem_ack,
      .o_irq_out_n, .o_exc_start, .o_mem_req, .o_mem_op, .o_fetch_start,
      .o_resp_cycles);
   cpu_mem_model mem (.i_clk_sys, .i_rstn, .i_mem_req(o_mem_req),
      .i_lat(lat), .o_mem_ack(i_mem_ack));
   initial begin
      forever #5 i_clk_sys = ~i_clk_sys;
   end
   function automatic int unsigned rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task end_sim();
      $display("counts: comparisons=%0d n_fail=%0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   always @(posedge i_clk_sys) begin
      cyc++;
      if (o_mem_req === 1'b1 && i_mem_ack === 1'b1) ops.push_back(o_mem_op);
      if (cyc > 20000) begin
         n_fail++;
         end_sim();
      end
   end
   // Kinds: 0 nmi, 1 on-chip, 2 pin level, 3 pin edge, 4 pin switch, 5 none
   task go(input int kind, input int lim, input int wc);
      int te;
      te = 0;
      got = 0;
      ops = {};
      case (kind)
         0: i_nmi_req <= 1'b1;
         1: i_onchip_req <= 1'b1;
         2: begin
            i_sense_edge[0] <= 1'b0;
            i_irq_pin_n[0] <= 1'b0;
         end
         3: begin
            i_sense_edge[0] <= 1'b1;
            i_irq_pin_n[0] <= 1'b0;
         end
         4: i_pin_is_irq[0] <= 1'b1;
         default: ;
      endcase
      if (wc > 0) i_cpu_busy <= 1'b1;
      for (int n = 0; n < lim && got == 0; n++) begin
         @(posedge i_clk_sys);
         if (n == wc) i_cpu_busy <= 1'b0;
         if (n == 0 && kind == 3) i_irq_pin_n[0] <= 1'b1;
         if (o_exc_start === 1'b1) begin
            `CHK(o_irq_out_n, 1'b0)
            te = n;
            i_nmi_req <= 1'b0;
            i_onchip_req <= 1'b0;
            i_irq_pin_n <= 8'hff;
         end
         if (o_fetch_start === 1'b1) begin
            got = 1;
            ivl = n - te;
            resp = o_resp_cycles;
         end
      end
   endtask
   task xfer(input int kind, input int wc);
      int base;
      base = (kind >= 2 ? 8 : 7) + 3 * lat;
      go(kind, 300, wc);
      `CHK(got, 1)
      `CHK(ivl, 5 + 3 * lat)
      if (wc == 0) `CHK(resp, 16'(base))
      else `CHK(resp >= base && resp <= base + wc, 1'b1)
      repeat (lat + 3) @(posedge i_clk_sys);
      `CHK(ops.size(), 4)
      for (int i = 0; i < 4 && i < ops.size(); i++)
         `CHK(ops[i], irt_pkg::mem_op_t'(i))
      `CHK(o_irq_out_n, 1'b1)
   endtask
   initial begin
      repeat (20) @(posedge i_clk_sys);
      i_rstn <= 1'b1;
      @(posedge i_clk_sys);
      for (int l = 1; l <= 4; l++) begin
         lat <= 3'(l);
         @(posedge i_clk_sys);
         xfer(0, 0);
      end
      $display("test nmi latencies done");
      repeat (4) begin
         r = rnd();
         m = r % 15;
         i_sr_mask <= 4'(m);
         i_onchip_level <= 4'(m + 1 + (r >> 4) % (15 - m));
         lat <= 3'(1 + (r >> 8) % 4);
         @(posedge i_clk_sys);
         xfer(1, 0);
      end
      i_onchip_level <= 4'h5;
      i_sr_mask <= 4'h5;
      go(1, 40, 0);
      `CHK(got, 0)
      i_onchip_req <= 1'b0;
      i_irq_level <= 4'h5;
      go(2, 40, 0);
      `CHK(got, 0)
      i_sr_mask <= 4'h0;
      i_irq_level <= 4'hf;
      $display("test on-chip mask done");
      xfer(2, 0);
      xfer(3, 0);
      $display("test pin sense done");
      xfer(0, 6);
      i_mask_hold <= 1'b1;
      go(0, 30, 0);
      `CHK(got, 0)
      `CHK(o_irq_out_n, 1'b0)
      i_mask_hold <= 1'b0;
      go(0, 100, 0);
      `CHK(got, 1)
      $display("test cpu wait done");
      repeat (8) @(posedge i_clk_sys);
      i_sense_edge[0] <= 1'b1;
      i_pin_is_irq[0] <= 1'b0;
      i_irq_pin_n[0] <= 1'b0;
      go(5, 6, 0);
      `CHK(got, 0)
      go(4, 60, 0);
      `CHK(got, 1)
      repeat (8) @(posedge i_clk_sys);
      i_pin_is_irq[0] <= 1'b0;
      go(5, 6, 0);
      go(4, 30, 0);
      `CHK(got, 0)
      $display("test pin switch done");
      end_sim();
   end
endmodule // interrupt_response_timing_test
